// File: hdl/serial_peripheral_port_quad.sv
// Serial peripheral port with master, slave, header-sync, pulse and four-line modes.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module serial_peripheral_port_quad import spi_quad_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial clock pin
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	// Select pin
	input wire logic sel_in,
	output logic sel_out,
	output logic sel_oe,
	// Data lines: 0 is master-out, 1 is master-in, 2 and 3 four-line only
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe
);

	state_t s;
	state_t next_s;

	// Received shifter contents aligned to the low bits of the word.
	function automatic logic [15:0] rx_align(input logic [15:0] r, input logic [4:0] len,
		input logic lsb, input logic quad);
		logic [15:0] m;
		m = 16'hffff >> (5'h10 - len);
		if (quad) begin
			rx_align = {8'h00, r[7:0]};
		end else if (lsb) begin
			rx_align = r >> (5'h10 - len);
		end else begin
			rx_align = r & m;
		end
	endfunction

	// Transmit word placed so the next bit out sits at a fixed end.
	function automatic logic [15:0] tx_prep(input logic [15:0] t, input logic [4:0] len,
		input logic lsb, input logic quad);
		if (quad) begin
			tx_prep = {t[7:0], 8'h00};
		end else if (lsb) begin
			tx_prep = t;
		end else begin
			tx_prep = t << (5'h10 - len);
		end
	endfunction

	// Byte-lane merge of a bus write into a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[8*i +: 8] = d[8*i +: 8];
			end
		end
	endfunction

	// Next-state logic for the bus slave and the shift engine.
	always_comb begin
		logic [CTRL_W-1:0] c;
		logic [4:0] len;
		logic [5:0] last;
		logic en, mst, quad, ti, cpol, cpha, lsb, rxonly, txd, seli, tick;
		logic ev, lead, din, sample, fdone, ld, wr, dbit, slv_on;
		logic [31:0] cw;
		next_s = s;
		c = s.ctrl;
		en = c[B_EN];
		mst = c[B_MST];
		quad = c[B_QUAD];
		ti = c[B_TI] & ~quad;
		cpol = ti ? 1'h0 : c[B_CPOL];
		cpha = ti ? 1'h1 : c[B_CPHA];
		lsb = c[B_LSB] & ~quad;
		len = quad ? 5'h02 : {1'h0, c[B_DS +: 4]} + 5'h01;
		last = {len, 1'h0} - 6'h01;
		rxonly = ~quad & (c[B_RO] | (c[B_BD] & ~c[B_BDOE]));
		txd = ~c[B_RO] & (~c[B_BD] | c[B_BDOE]);
		seli = c[B_SWEN] ? c[B_SWLVL] : sel_in;
		tick = s.div == ((8'h01 << c[B_DIV +: 3]) - 8'h01);
		ev = 1'h0;
		lead = 1'h0;
		din = 1'h0;
		sample = 1'h0;
		fdone = 1'h0;
		ld = 1'h0;
		wr = s.aw_got & s.w_got & ~s.bvalid;
		cw = 32'h0;
		dbit = 1'h0;
		slv_on = 1'h0;
		next_s.sck_d = sck_in;
		next_s.seli_d = sel_in;

		// Bus channels: each address and data beat accepted once, one at a time.
		next_s.awready = awvalid & ~s.awready & ~s.aw_got & ~s.bvalid;
		next_s.wready = wvalid & ~s.wready & ~s.w_got & ~s.bvalid;
		next_s.arready = arvalid & ~s.arready & ~s.rvalid;
		if (awvalid & s.awready) begin
			next_s.aw_got = 1'h1;
			next_s.awaddr = awaddr;
		end
		if (wvalid & s.wready) begin
			next_s.w_got = 1'h1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (s.bvalid & bready) begin
			next_s.bvalid = 1'h0;
		end
		if (s.rvalid & rready) begin
			next_s.rvalid = 1'h0;
		end
		if (wr) begin
			next_s.aw_got = 1'h0;
			next_s.w_got = 1'h0;
			next_s.bvalid = 1'h1;
			next_s.bresp = RESP_OK;
			if (s.awaddr == CTRL_ADDR) begin
				cw = merge({7'h00, s.ctrl}, s.wdata, s.wstrb);
				next_s.ctrl = cw[CTRL_W-1:0];
			end else if (s.awaddr == STAT_ADDR) begin
				// Error flags clear on writing one; a same-cycle event wins below.
				next_s.ovr = s.ovr & ~(s.wstrb[0] & s.wdata[S_OVR]);
				next_s.frame_error = s.frame_error & ~(s.wstrb[0] & s.wdata[S_FRAME_ERROR]);
				next_s.cerr = s.cerr & ~(s.wstrb[0] & s.wdata[S_CERR]);
			end else if (s.awaddr != DATA_ADDR) begin
				next_s.bresp = RESP_ERR;
			end
		end
		if (arvalid & s.arready) begin
			next_s.rvalid = 1'h1;
			next_s.rresp = RESP_OK;
			next_s.rdata = 32'h0;
			if (araddr == CTRL_ADDR) begin
				next_s.rdata[CTRL_W-1:0] = s.ctrl;
			end else if (araddr == DATA_ADDR) begin
				next_s.rdata[15:0] = s.rxbuf;
				next_s.rx_full = 1'h0;
			end else if (araddr == STAT_ADDR) begin
				next_s.rdata[S_TBE] = ~s.tx_full;
				next_s.rdata[S_RX_NOT_EMPTY_FLAG] = s.rx_full;
				next_s.rdata[S_OVR] = s.ovr;
				next_s.rdata[S_BUSY] = s.eng != ST_IDLE;
				next_s.rdata[S_FRAME_ERROR] = s.frame_error;
				next_s.rdata[S_CERR] = s.cerr;
			end else begin
				next_s.rresp = RESP_ERR;
			end
		end

		// Slave hold countdown after a header-sync frame.
		if (s.hold != 9'h000) begin
			next_s.hold = s.hold - 9'h001;
		end

		// Shift engine sequencing.
		case (s.eng)
			ST_IDLE: begin
				next_s.edges = 6'h00;
				next_s.div = 8'h00;
				next_s.sck = cpol;
				if (en & mst & (s.tx_full | rxonly)) begin
					ld = 1'h1;
					next_s.sel = ti;
					next_s.eng = ti ? ST_HEAD : ST_SHIFT;
				end else if (en & ~mst & (ti | ~seli)) begin
					ld = 1'h1;
					next_s.eng = ST_SLAVE;
				end
			end
			ST_HEAD: begin
				next_s.div = tick ? 8'h00 : s.div + 8'h01;
				if (tick) begin
					// One extra clock with select high ahead of the byte.
					next_s.sck = ~s.sck;
					next_s.edges = s.edges + 6'h01;
					if (s.edges == 6'h01) begin
						next_s.edges = 6'h00;
						next_s.sel = 1'h0;
						next_s.eng = ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				next_s.div = tick ? 8'h00 : s.div + 8'h01;
				if (tick) begin
					next_s.sck = ~s.sck;
					ev = 1'h1;
					lead = ~s.sck != cpol;
					din = c[B_BD] ? io_in[0] : io_in[1];
					// Continuous header overlays the previous byte's last bit.
					if (ti & (s.edges == last - 6'h01) & s.tx_full) begin
						next_s.sel = 1'h1;
					end
				end
			end
			ST_GAP: begin
				next_s.sel = 1'h1;
				next_s.div = tick ? 8'h00 : s.div + 8'h01;
				if (tick & (s.edges != 6'h02)) begin
					next_s.edges = s.edges + 6'h01;
				end
				if ((s.edges == 6'h02) & s.tx_full) begin
					ld = 1'h1;
					next_s.edges = 6'h00;
					next_s.sel = 1'h0;
					next_s.eng = ST_SHIFT;
				end else if (s.edges == 6'h02) begin
					// Buffer still empty: wait in idle, select stays high until data comes.
					next_s.edges = 6'h00;
					next_s.eng = ST_IDLE;
				end
			end
			ST_SLAVE: begin
				if (~ti & seli) begin
					next_s.eng = ST_IDLE;
				end else if (sck_in != s.sck_d) begin
					ev = 1'h1;
					lead = sck_in != cpol;
					din = c[B_BD] ? io_in[1] : io_in[0];
				end
				if (ti & (sel_in != s.seli_d) & (s.edges != 6'h00)) begin
					next_s.frame_error = 1'h1;
				end
			end
			default: begin
				next_s.eng = ST_IDLE;
			end
		endcase

		// Common edge handling for both roles.
		if (ev) begin
			next_s.edges = s.edges + 6'h01;
			sample = lead ^ cpha;
			if (sample) begin
				if (quad) begin
					next_s.rsh = {s.rsh[11:0], io_in};
				end else if (lsb) begin
					next_s.rsh = {din, s.rsh[15:1]};
				end else begin
					next_s.rsh = {s.rsh[14:0], din};
				end
			end else if (!(cpha & (s.edges == 6'h00))) begin
				if (quad) begin
					next_s.tsh = {s.tsh[11:0], 4'h0};
				end else if (lsb) begin
					next_s.tsh = {1'h0, s.tsh[15:1]};
				end else begin
					next_s.tsh = {s.tsh[14:0], 1'h0};
				end
			end
			if (s.edges == last) begin
				fdone = 1'h1;
				next_s.edges = 6'h00;
			end
		end

		// Frame end: deliver the word, then continue, pause or stop.
		if (fdone) begin
			if (next_s.rx_full) begin
				next_s.ovr = 1'h1;
			end else begin
				next_s.rxbuf = rx_align(next_s.rsh, len, lsb, quad);
				next_s.rx_full = 1'h1;
			end
			if (s.eng == ST_SLAVE) begin
				ld = 1'h1;
				if (ti) begin
					next_s.hold = (9'h001 << c[B_DIV +: 3]) + HOLD_EXTRA_CYC;
				end
			end else if (c[B_PULSE]) begin
				next_s.eng = ST_GAP;
				next_s.sel = 1'h1;
				next_s.div = 8'h00;
			end else if (en & (s.tx_full | rxonly)) begin
				ld = 1'h1;
				next_s.sel = ti & ~s.sel;
				next_s.eng = (ti & ~s.sel) ? ST_HEAD : ST_SHIFT;
			end else begin
				next_s.eng = ST_IDLE;
				next_s.sel = 1'h0;
			end
		end

		// Transmit buffer to shifter move; buffer empties unless refilled below.
		if (ld) begin
			next_s.tsh = s.tx_full ? tx_prep(s.txbuf, len, lsb, quad) : 16'h0000;
			next_s.tx_full = 1'h0;
		end

		// A bus data write refills the buffer and wins over the move above.
		if (wr & (s.awaddr == DATA_ADDR)) begin
			cw = merge({16'h0000, s.txbuf}, s.wdata, s.wstrb);
			next_s.txbuf = cw[15:0];
			next_s.tx_full = 1'h1;
		end

		// Select sensed low while master with select as input.
		if (en & mst & (c[B_SWEN] | ~c[B_SELDRV]) & ~seli) begin
			next_s.ctrl[B_MST] = 1'h0;
			next_s.cerr = 1'h1;
			next_s.eng = ST_IDLE;
		end
		if (~en) begin
			next_s.eng = ST_IDLE;
			next_s.sel = 1'h1;
		end else if ((next_s.eng == ST_IDLE) & ~c[B_PULSE]) begin
			next_s.sel = 1'h0;
		end

		// Pin drive from the settled next state.
		dbit = lsb ? next_s.tsh[0] : next_s.tsh[15];
		next_s.dout = quad ? next_s.tsh[15:12] : {2'h0, dbit, dbit};
		slv_on = (next_s.eng == ST_SLAVE) & (~ti | (next_s.edges != 6'h00) | (next_s.hold != 9'h000));
		if (en & next_s.ctrl[B_MST] & quad) begin
			next_s.doe = c[B_QRD] ? 4'h0 : 4'hf;
		end else begin
			next_s.doe = {2'h0, en & ~next_s.ctrl[B_MST] & txd & slv_on,
				en & next_s.ctrl[B_MST] & txd};
		end
		next_s.sck_oe = en & next_s.ctrl[B_MST];
		next_s.sel_oe = next_s.ctrl[B_MST] & ~next_s.ctrl[B_SWEN] & next_s.ctrl[B_SELDRV];
	end

	// State register.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.ctrl <= CTRL_RESET;
			s.sel <= 1'h1;
			s.seli_d <= 1'h1; // Idle select level, so no false edge follows reset.
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state register.
	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign sck_out = s.sck;
	assign sck_oe = s.sck_oe;
	assign sel_out = s.sel;
	assign sel_oe = s.sel_oe;
	assign io_out = s.dout;
	assign io_oe = s.doe;

endmodule

// File: hdl/spi_quad_pkg.sv
// Constants, field layout and state types of the serial peripheral port.
//
// Contract
// - Divider sets clock rate or header hold.
// - Enabled port idles; master starts on write.
// - Slave shifts on clock edges while selected.
// - Frame loads shifter, then transmit-empty rises.
// - Early next write gives gapless master frames.
// - Frame end fills receive buffer, sets flag.
// - Receive-only master clocks on; duplex waits data.
// - Unread receive word plus new word flags overrun.
// - Header mode ignores polarity/phase, samples falling.
// - Header master adds header clock, overlaps when continuous.
// - Header slave keeps its data line driven half-bit plus five.
// - Header slave flags select toggling mid-frame.
// - Pulse mode raises select a period between frames.
// - Read bit chooses four-line write or read.
// - Four-line write drives all lines on write.
// - Four-line stops when transmit buffer empty.
// - Low select in master forces slave, error.
// - Four-line read inputs; dummy write clocks byte.
package spi_quad_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
	localparam logic [ADDR_W-1:0] DATA_ADDR = 4'h4;
	localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h8;
	localparam int B_DIV = 0;
	localparam int B_CPOL = 3;
	localparam int B_CPHA = 4;
	localparam int B_MST = 5;
	localparam int B_LSB = 6;
	localparam int B_SWEN = 7;
	localparam int B_SWLVL = 8;
	localparam int B_SELDRV = 9;
	localparam int B_RO = 10;
	localparam int B_BD = 11;
	localparam int B_BDOE = 12;
	localparam int B_EN = 13;
	localparam int B_TI = 14;
	localparam int B_PULSE = 15;
	localparam int B_QUAD = 16;
	localparam int B_QRD = 17;
	localparam int B_DS = 18;
	localparam int CTRL_W = 25;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 25'h01c0000;
	localparam int S_TBE = 0;
	localparam int S_RX_NOT_EMPTY_FLAG = 1;
	localparam int S_OVR = 2;
	localparam int S_BUSY = 3;
	localparam int S_FRAME_ERROR = 4;
	localparam int S_CERR = 5;
	localparam logic [8:0] HOLD_EXTRA_CYC = 9'h005;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_HEAD, ST_SHIFT, ST_GAP, ST_SLAVE} eng_t;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] txbuf;
		logic tx_full;
		logic [15:0] rxbuf;
		logic rx_full;
		logic ovr;
		logic frame_error;
		logic cerr;
		logic [15:0] tsh;
		logic [15:0] rsh;
		logic [5:0] edges;
		logic [7:0] div;
		logic [8:0] hold;
		eng_t eng;
		logic sck;
		logic sck_oe;
		logic sel;
		logic sel_oe;
		logic [3:0] dout;
		logic [3:0] doe;
		logic sck_d;
		logic seli_d;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;
endpackage

// File: test/spq_checker.sv
// Assertions on the pins and register bus of the serial peripheral port.
`timescale 1ns/10ps
module spq_checker import spi_quad_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register bus
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	// Serial pins
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sel_in,
	input wire logic sel_out,
	input wire logic sel_oe,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe
);
	logic [ADDR_W-1:0] wa;
	logic [31:0] wd;
	logic [CTRL_W-1:0] ctl;
	logic mode0;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Shadow of the control word, taken when its write is answered.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wa <= '0;
			wd <= '0;
			ctl <= CTRL_RESET;
		end else begin
			if (awvalid && awready) wa <= awaddr;
			if (wvalid && wready) wd <= wdata;
			if (bvalid && bready && wa == CTRL_ADDR) ctl <= wd[CTRL_W-1:0];
		end
	end
	// Plain mode-0 master that drives the master-out line.
	assign mode0 = ctl[B_MST] && !ctl[B_TI] && !ctl[B_QUAD] && !ctl[B_RO] && ctl[4:3] == 2'h0;
	quad_lines_a: assert property (io_oe[3:2] != 2'h0 |-> io_oe == 4'hf)
		else $error("four-line drive is partial");
	quad_write_a: assert property (io_oe == 4'hf |-> ctl[B_QUAD] && !ctl[B_QRD])
		else $error("all lines driven outside four-line write");
	pulse_gap_a: assert property ($rose(sel_out) && sel_oe |-> sel_out [*2])
		else $error("select pulse too short");
	div_rate_a: assert property (
		sck_oe && $changed(sck_out) && ctl[2:0] == 3'h1 |=> $stable(sck_out))
		else $error("serial clock half period wrong");
	mosi_setup_a: assert property (mode0 && $rose(sck_out) |-> $stable(io_out[0]))
		else $error("data moved on the sampling edge");
	conf_err_a: assert property (
		ctl[B_MST] && ctl[B_EN] && !ctl[B_SWEN] && !ctl[B_SELDRV] && !sel_in |-> ##[1:4] !sck_oe)
		else $error("low select left the port a master");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	cover property (io_oe == 4'hf);
	cover property ($rose(sel_out) && sel_oe);
	cover property (sck_oe && ctl[B_RO]);
endmodule

// File: test/spq_slave_model.sv
// Behavioural external serial slave in clock mode 0 that echoes the last word.
`timescale 1ns/10ps
module spq_slave_model (
	// Pins seen from the slave
	input wire logic sck,
	input wire logic sel,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] sr = 8'ha5;
	logic cap = 1'b0;
	// Sample on the rising edge, shift on the falling one; the word is ready early.
	always @(posedge sck) cap <= mosi;
	always @(negedge sck) sr <= {sr[6:0], cap};
	// A deselected slave floats the line, shown here as the inverse of its bit.
	assign miso = sel ? ~sr[7] : sr[7];
endmodule

// File: test/serial_peripheral_port_quad_tb_top.sv
// Bench of the serial peripheral port with a model slave on the far side.
`timescale 1ns/10ps
module serial_peripheral_port_quad_tb_top import spi_quad_pkg::*;;
	localparam logic [31:0] BASE = 32'h1 << B_EN | 32'h1 << B_MST
		| 32'h1 << B_SELDRV | 32'h7 << B_DS;
	logic sys_clk = 1'b0, resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic bready = 1'b1, rready = 1'b1, sck_in = 1'b0, sel_drv = 1'b1;
	logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf;
	logic [31:0] wdata = '0, rdata, s;
	logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, sel_in, sel_out, sel_oe, miso;
	logic [1:0] bresp, rresp, lb, lr;
	logic [3:0] io_in, io_out, io_oe;
	logic [16:0] rn = 17'h18415;
	logic [7:0] q[$] = '{8'ha5};
	logic [7:0] qn = 8'h0, tx, rxw, txw;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	// Each line carries whoever drives it, otherwise the bench select level, the slave's miso on line 1, or a changing pattern.
	assign sel_in = sel_oe ? sel_out : sel_drv;
	assign io_in = (io_oe & io_out) | (~io_oe & {rn[1:0], miso, rn[2]});
	serial_peripheral_port_quad dut (.sys_clk, .resetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sck_in, .sck_out, .sck_oe, .sel_in, .sel_out, .sel_oe, .io_in,
		.io_out, .io_oe);
	spq_slave_model slave (.sck(sck_out), .sel(sel_out), .mosi(io_in[0]), .miso(miso));
	function automatic logic [16:0] lf(input logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction
	function automatic logic [7:0] rev(input logic [7:0] x);
		return {x[0], x[1], x[2], x[3], x[4], x[5], x[6], x[7]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Bus write: each channel released when taken, then wait for the answer.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ha = awready;
			hw = wready;
			hb = bvalid;
			lb = bresp;
			@(posedge sys_clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end while (!hb);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		logic ha, hr;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge sys_clk);
			ha = arready;
			hr = rvalid;
			d = rdata;
			lr = rresp;
			@(posedge sys_clk);
			if (ha) arvalid <= 1'b0;
		end while (!hr);
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] st;
		do rd(STAT_ADDR, st);
		while ((st & m) !== v);
	endtask
	// One duplex frame; the slave answers with the word it held, in wire order.
	task automatic frame(input logic lsb);
		tx = rn[7:0];
		wr(DATA_ADDR, {24'h0, tx});
		poll(32'h2, 32'h2);
		rd(DATA_ADDR, s);
		chk(s, {24'h0, lsb ? rev(q[0]) : q[0]});
		void'(q.pop_front());
		q.push_back(lsb ? rev(tx) : tx);
		rd(STAT_ADDR, s);
		chk(s, 32'h1);
	endtask
	// Nibbles seen on the four lines at each sampling edge.
	always @(posedge sck_out) if (io_oe == 4'hf) qn <= {qn[3:0], io_out};
	// Clock, pattern source and hang guard.
	initial forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		rn <= lf(rn);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	// Main sequence.
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		rd(CTRL_ADDR, s);
		chk(s, 32'(CTRL_RESET));
		rd(STAT_ADDR, s);
		chk(s, 32'h1);
		rd(4'hc, s);
		chk(s, 32'h0);
		chk(32'(lr), 32'(RESP_ERR));
		wr(4'hc, 32'h0);
		chk(32'(lb), 32'(RESP_ERR));
		for (int i = 0; i < 4; i++) begin
			// Set up with the port off, then turn it on by itself.
			wr(CTRL_ADDR, BASE & ~(32'h1 << B_EN) | 32'(i[1]) | 32'(i[0]) << B_LSB);
			wr(CTRL_ADDR, BASE | 32'(i[1]) | 32'(i[0]) << B_LSB);
			repeat (3) frame(i[0]);
		end
		wr(CTRL_ADDR, BASE);
		wr(DATA_ADDR, 32'h3c);
		wr(DATA_ADDR, 32'hc3);
		poll(32'hf, 32'h7);
		rd(DATA_ADDR, s);
		chk(s, {24'h0, q[0]});
		wr(STAT_ADDR, 32'h4);
		rd(STAT_ADDR, s);
		chk(s, 32'h1);
		wr(CTRL_ADDR, BASE | 32'h1 << B_RO);
		poll(32'h2, 32'h2);
		rd(DATA_ADDR, s);
		poll(32'h6, 32'h6);
		wr(CTRL_ADDR, BASE);
		poll(32'h8, 32'h0);
		rd(DATA_ADDR, s);
		wr(CTRL_ADDR, BASE | 32'h1 << B_PULSE);
		wr(DATA_ADDR, 32'h5a);
		wr(DATA_ADDR, 32'ha5);
		poll(32'h9, 32'h1);
		wr(CTRL_ADDR, BASE | 32'h1 << B_QUAD);
		repeat (2) begin
			tx = rn[7:0];
			wr(DATA_ADDR, {24'h0, tx});
			poll(32'h9, 32'h1);
			chk(32'(qn), 32'(tx));
		end
		wr(CTRL_ADDR, BASE & ~(32'h1 << B_SELDRV));
		sel_drv <= 1'b0;
		poll(32'h20, 32'h20);
		sel_drv <= 1'b1;
		wr(STAT_ADDR, 32'h24);
		rd(STAT_ADDR, s);
		chk(s & 32'h24, 32'h0);
		// Slave frame: the bench selects and clocks, the preloaded word goes out.
		rd(DATA_ADDR, s);
		wr(CTRL_ADDR, 32'h7 << B_DS);
		tx = rn[7:0];
		wr(DATA_ADDR, {24'h0, tx});
		wr(CTRL_ADDR, 32'h7 << B_DS | 32'h1 << B_EN);
		sel_drv <= 1'b0;
		repeat (2) @(posedge sys_clk);
		repeat (8) begin
			sck_in <= 1'b1;
			@(negedge sys_clk);
			rxw = {rxw[6:0], io_in[0]};
			txw = {txw[6:0], io_out[1]};
			@(posedge sys_clk);
			sck_in <= 1'b0;
			@(posedge sys_clk);
		end
		sel_drv <= 1'b1;
		chk(32'(txw), 32'(tx));
		poll(32'h2, 32'h2);
		rd(DATA_ADDR, s);
		chk(s, 32'(rxw));
		finish_test();
	end
endmodule
bind serial_peripheral_port_quad spq_checker chk_i (.sys_clk, .resetn, .awaddr, .awvalid,
	.awready, .wdata, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .sck_out,
	.sck_oe, .sel_in, .sel_out, .sel_oe, .io_out, .io_oe);
